// ==== ppc_far_side.sv ====
// far side: pulled-up class line and status led line
`timescale 1ns/1ps
module ppc_far_side (
    // clock
    input  wire logic mclk_in,
    // device drive
    input  wire logic class_oe_in,
    input  wire logic status_oe_in,
    input  wire logic status_drv_in,
    // resolved levels
    output logic      class_pin_out,
    output logic      status_pin_out
);
    logic noise = 1'b0;
    // undriven status line reads as noise
    always_ff @(posedge mclk_in) begin
        noise <= !noise;
    end
    // open drain with pull-up, high enables class feedback
    assign class_pin_out  = class_oe_in ? 1'b0 : 1'b1;
    assign status_pin_out = status_oe_in ? status_drv_in : noise;
endmodule : ppc_far_side

// ==== ppc_pkg.sv ====
// shared constants and types for the port pin controller
package ppc_pkg;

    // clock rate
    localparam int CLK_HZ          = 20_000_000;

    // led flash rates in milli-flashes per second
    localparam int SLOW_FLASH_MHZ  = 1500;
    localparam int FAST_FLASH_MHZ  = 10000;
    // half periods, rounded down
    // worked in 64 bits, the product would overflow an int
    localparam int SLOW_HALF_CYC   =
        int'(longint'(CLK_HZ) / 2 * 1000 / SLOW_FLASH_MHZ);
    localparam int FAST_HALF_CYC   =
        int'(longint'(CLK_HZ) / 2 * 1000 / FAST_FLASH_MHZ);

    // automatic restart delay after an error
    localparam int RESTART_MS      = 2200;
    localparam int RESTART_CYC     = CLK_HZ / 1000 * RESTART_MS;

    // one detection voltage step and one classification phase
    localparam int DET_STEP_MS     = 10;
    localparam int DET_STEP_CYC    = CLK_HZ / 1000 * DET_STEP_MS;
    localparam int CLASS_PHASE_MS  = 10;
    localparam int CLASS_PHASE_CYC = CLK_HZ / 1000 * CLASS_PHASE_MS;

    // settling time before the status pin level is sampled
    localparam int CFG_SETTLE_CYC  = 16;

    // index of the last detection voltage step, so three steps
    localparam logic [1:0] DET_STEPS_LAST = 2'h2;

    // apb register byte offsets
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] DUTY_OFS  = 8'h04;
    localparam logic [7:0] GATE_OFS  = 8'h08;
    localparam logic [7:0] STAT_OFS  = 8'h0C;

    // register reset values
    localparam logic        CTRL_RUN_RST = 1'b1;
    localparam logic [23:0] DUTY_RST     = 24'hC0_8040;
    localparam logic [15:0] GATE_RST     = 16'hFF00;

    // configuration code fields, sampled from the status pin level
    localparam int CFG_PWR_LSB = 0;
    localparam int CFG_MID_BIT = 2;
    localparam int CFG_RAD_BIT = 3;

    // status register field positions
    localparam int STAT_CFG_LSB = 3;
    localparam int STAT_LED_BIT = 7;
    localparam int STAT_PIN_BIT = 8;
    localparam int STAT_CLS_BIT = 9;
    localparam int STAT_DET_BIT = 10;

    // operating states
    typedef enum logic [2:0] {
        PPC_IDLE,
        PPC_CONFIG,
        PPC_DETECT,
        PPC_CLASS,
        PPC_POWER,
        PPC_ERROR
    } ppc_state_t;

endpackage : ppc_pkg

// ==== ppc_props.sv ====
// assertions on the port pin controller pins
`timescale 1ns/1ps
module ppc_props #(
    parameter int CLASS_PHASE_CYC = ppc_pkg::CLASS_PHASE_CYC
) (
    // clock and reset
    input wire logic       mclk_in,
    input wire logic       rst_n_in,
    // apb
    input wire logic       psel_in,
    input wire logic       penable_in,
    input wire logic [7:0] paddr_in,
    input wire logic       pready_out,
    input wire logic       pslverr_out,
    // pins
    input wire logic       coarse_pwm_out,
    input wire logic       mark_current_boost_out,
    input wire logic       class_voltage_enable_out,
    input wire logic       class_voltage_enable_oe_out,
    input wire logic       status_pin_out,
    input wire logic       status_pin_oe_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    logic [8:0]  hi_run;
    logic [15:0] bst_run;
    // run lengths of coarse high and boost high
    always_ff @(posedge mclk_in) begin
        hi_run  <= (rst_n_in && coarse_pwm_out) ? hi_run + 9'h001 : 9'h000;
        bst_run <= (rst_n_in && mark_current_boost_out) ?
                   bst_run + 16'h0001 : 16'h0000;
    end
    property p_reset_quiet;
        disable iff (1'b0)
        !rst_n_in |=> !coarse_pwm_out && !mark_current_boost_out &&
            class_voltage_enable_oe_out && !status_pin_out &&
            !status_pin_oe_out;
    endproperty
    property p_od_low;
        !class_voltage_enable_out;
    endproperty
    property p_oe_keep;
        status_pin_oe_out |=> status_pin_oe_out;
    endproperty
    property p_cfg_wait;
        $rose(rst_n_in) |-> !status_pin_oe_out [*8] ##[1:30] status_pin_oe_out;
    endproperty
    property p_boost_len;
        $fell(mark_current_boost_out) |-> bst_run >= CLASS_PHASE_CYC - 2 &&
            bst_run <= CLASS_PHASE_CYC + 2;
    endproperty
    property p_boost_led;
        mark_current_boost_out |-> !status_pin_out;
    endproperty
    property p_led_min;
        $rose(status_pin_out) |-> status_pin_out [*8];
    endproperty
    property p_coarse_max;
        hi_run <= 9'h0FF;
    endproperty
    property p_apb_ready;
        psel_in && !penable_in |=> pready_out;
    endproperty
    property p_apb_err;
        psel_in && !penable_in && paddr_in[7:4] != 4'h0 |=> pslverr_out;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active in reset");
    a_od_low: assert property (p_od_low)
        else $error("class enable driven high");
    a_oe_keep: assert property (p_oe_keep)
        else $error("status output released");
    a_cfg_wait: assert property (p_cfg_wait)
        else $error("status sensing window wrong");
    a_boost_len: assert property (p_boost_len)
        else $error("boost length wrong");
    a_boost_led: assert property (p_boost_led)
        else $error("led on during boost");
    a_led_min: assert property (p_led_min)
        else $error("led pulse too short");
    a_coarse_max: assert property (p_coarse_max)
        else $error("coarse pwm high too long");
    a_apb_ready: assert property (p_apb_ready)
        else $error("no ready after setup");
    a_apb_err: assert property (p_apb_err)
        else $error("no error for unmapped address");
    c_boost: cover property ($rose(mark_current_boost_out));
    c_err: cover property (pslverr_out);
    c_cfg: cover property ($rose(status_pin_oe_out));
endmodule : ppc_props

// ==== ppc_pwm.sv ====
// 8-bit duty-cycle pwm generator
`timescale 1ns/1ps
module ppc_pwm (
    // clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rst_n_in,
    // duty and output
    input  wire logic [7:0] duty_in,
    output logic            pwm_out
);

    typedef struct packed {
        logic [7:0] cnt;
        logic       out;
    } ppc_pwm_st_t;

    ppc_pwm_st_t r;
    ppc_pwm_st_t next_r;

    // free-running ramp compared against the duty
    always_comb begin
        next_r     = r;
        next_r.cnt = r.cnt + 8'h01;
        next_r.out = (r.cnt < duty_in);
    end

    // state register
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign pwm_out = r.out;

endmodule : ppc_pwm

// ==== ppc_sync2.sv ====
// two-stage level synchroniser
`timescale 1ns/1ps
module ppc_sync2 (
    // clock and reset
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    // level in and out
    input  wire logic d_in,
    output logic      q_out
);

    typedef struct packed {
        logic s1;
        logic s2;
    } ppc_sync_st_t;

    ppc_sync_st_t r;
    ppc_sync_st_t next_r;

    // first stage feeds only the second
    always_comb begin
        next_r    = r;
        next_r.s1 = d_in;
        next_r.s2 = r.s1;
    end

    // state register
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q_out = r.s2;

endmodule : ppc_sync2

// ==== ppc_top.sv ====
// port pin controller: sequencing, pwm drive, status led and apb regs
`timescale 1ns/1ps
module ppc_top #(
    parameter int SLOW_HALF_CYC   = ppc_pkg::SLOW_HALF_CYC,
    parameter int FAST_HALF_CYC   = ppc_pkg::FAST_HALF_CYC,
    parameter int RESTART_CYC     = ppc_pkg::RESTART_CYC,
    parameter int DET_STEP_CYC    = ppc_pkg::DET_STEP_CYC,
    parameter int CLASS_PHASE_CYC = ppc_pkg::CLASS_PHASE_CYC
) (
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // analog front end, as comparator results
    input  wire logic        detect_sense_in,
    input  wire logic [2:0]  class_code_in,
    input  wire logic        fault_in,
    input  wire logic        open_circuit_in,
    // pwm and classification drive
    output logic             coarse_pwm_out,
    output logic             fine_pwm_out,
    output logic             mark_current_boost_out,
    input  wire logic        class_voltage_enable_in,
    output logic             class_voltage_enable_out,
    output logic             class_voltage_enable_oe_out,
    // status pin
    input  wire logic [3:0]  status_level_in,
    input  wire logic        status_pin_in,
    output logic             status_pin_out,
    output logic             status_pin_oe_out
);

    typedef struct packed {
        ppc_pkg::ppc_state_t st;
        logic [31:0]         cnt;
        logic [31:0]         flash;
        logic [1:0]          step;
        logic                det_ok;
        logic [3:0]          cfg;
        logic                run;
        logic [23:0]         duty;
        logic [15:0]         gate;
        logic [7:0]          coarse;
        logic [7:0]          fine;
        logic                pwm_c;
        logic                pwm_f;
        logic                led;
        logic                led_oe;
        logic                boost;
        logic                cls_en;
        logic                cls_oe;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
    } ppc_top_st_t;

    ppc_top_st_t r;
    ppc_top_st_t next_r;
    logic        rst_sync;
    logic        coarse_pwm;
    logic        fine_pwm;
    logic        setup;
    logic        access;
    logic        mapped;
    logic        excess;
    logic [31:0] rd_word;

    // reset pin brought into the clock domain
    ppc_sync2 u_rst_sync (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .d_in     (1'b1),
        .q_out    (rst_sync)
    );

    // coarse and fine pwm, 8-bit counters
    ppc_pwm u_coarse (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .duty_in  (r.coarse),
        .pwm_out  (coarse_pwm)
    );

    ppc_pwm u_fine (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .duty_in  (r.fine),
        .pwm_out  (fine_pwm)
    );

    // apb phase decode and register readback
    assign setup  = psel_in && !penable_in;
    assign access = psel_in && penable_in && r.pready;
    assign mapped = (paddr_in == ppc_pkg::CTRL_OFS) ||
                    (paddr_in == ppc_pkg::DUTY_OFS) ||
                    (paddr_in == ppc_pkg::GATE_OFS) ||
                    (paddr_in == ppc_pkg::STAT_OFS);
    assign excess = class_code_in > (3'(r.cfg[1:0]) + 3'h1);

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (paddr_in)
            ppc_pkg::CTRL_OFS: rd_word[0] = r.run;
            ppc_pkg::DUTY_OFS: rd_word[23:0] = r.duty;
            ppc_pkg::GATE_OFS: rd_word[15:0] = r.gate;
            ppc_pkg::STAT_OFS: begin
                rd_word[2:0] = r.st;
                rd_word[ppc_pkg::STAT_CFG_LSB +: 4] = r.cfg;
                rd_word[ppc_pkg::STAT_LED_BIT] = r.led;
                rd_word[ppc_pkg::STAT_PIN_BIT] = status_pin_in;
                rd_word[ppc_pkg::STAT_CLS_BIT] = class_voltage_enable_in;
                rd_word[ppc_pkg::STAT_DET_BIT] = r.det_ok;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // sequencer, led and register next state
    always_comb begin
        next_r     = r;
        next_r.cnt = r.cnt + 32'h1;

        // apb: answer in the cycle after setup
        next_r.pready  = setup;
        next_r.pslverr = setup && !mapped;
        if (setup) begin
            next_r.prdata = rd_word;
        end
        if (access && pwrite_in) begin
            unique case (paddr_in)
                ppc_pkg::CTRL_OFS: next_r.run  = pwdata_in[0];
                ppc_pkg::DUTY_OFS: next_r.duty = pwdata_in[23:0];
                ppc_pkg::GATE_OFS: next_r.gate = pwdata_in[15:0];
                default: next_r.run = r.run;
            endcase
        end

        // pwm outputs retimed through the state register
        next_r.pwm_c = coarse_pwm;
        next_r.pwm_f = fine_pwm;

        // defaults for the drive outputs
        next_r.boost  = 1'b0;
        next_r.cls_en = 1'b0;
        next_r.coarse = 8'h00;
        next_r.fine   = 8'h00;

        unique case (r.st)
            ppc_pkg::PPC_IDLE: begin
                next_r.cnt = 32'h0;
                if (rst_sync && r.run) begin
                    next_r.st = ppc_pkg::PPC_CONFIG;
                end
            end
            ppc_pkg::PPC_CONFIG: begin
                if (r.cnt >= 32'(ppc_pkg::CFG_SETTLE_CYC - 1)) begin
                    next_r.cfg    = status_level_in;
                    next_r.led_oe = 1'b1;
                    next_r.st     = ppc_pkg::PPC_DETECT;
                    next_r.cnt    = 32'h0;
                    next_r.step   = 2'h0;
                    next_r.det_ok = 1'b1;
                end
            end
            ppc_pkg::PPC_DETECT: begin
                // step through the detection voltages
                next_r.coarse = r.duty[r.step*8 +: 8];
                if (r.cnt >= 32'(DET_STEP_CYC - 1)) begin
                    next_r.cnt    = 32'h0;
                    next_r.det_ok = r.det_ok && detect_sense_in;
                    next_r.step   = r.step + 2'h1;
                    if (r.step == ppc_pkg::DET_STEPS_LAST) begin
                        next_r.step   = 2'h0;
                        next_r.det_ok = 1'b1;
                        if (r.det_ok && detect_sense_in) begin
                            next_r.st = ppc_pkg::PPC_CLASS;
                        end
                    end
                end
            end
            ppc_pkg::PPC_CLASS: begin
                // class event, then mark with boosted current
                if (r.cnt < 32'(CLASS_PHASE_CYC)) begin
                    next_r.cls_en = 1'b1;
                end else begin
                    next_r.boost = 1'b1;
                end
                if (r.cnt >= 32'(2 * CLASS_PHASE_CYC - 1)) begin
                    next_r.cnt    = 32'h0;
                    next_r.boost  = 1'b0;
                    next_r.st     = excess ? ppc_pkg::PPC_ERROR
                                           : ppc_pkg::PPC_POWER;
                end
            end
            ppc_pkg::PPC_POWER: begin
                next_r.coarse = r.gate[15:8];
                next_r.fine   = r.gate[7:0];
                if (fault_in) begin
                    next_r.coarse = 8'h00;
                    next_r.fine   = 8'h00;
                    next_r.cnt    = 32'h0;
                    next_r.st     = ppc_pkg::PPC_ERROR;
                end
            end
            ppc_pkg::PPC_ERROR: begin
                // wait out the restart or a disconnected load
                if (r.cfg[ppc_pkg::CFG_RAD_BIT]) begin
                    next_r.cnt = 32'h0;
                    if (open_circuit_in) begin
                        next_r.st = ppc_pkg::PPC_DETECT;
                    end
                end else if (r.cnt >= 32'(RESTART_CYC - 1)) begin
                    next_r.cnt = 32'h0;
                    next_r.st  = ppc_pkg::PPC_DETECT;
                end
            end
            default: next_r.st = ppc_pkg::PPC_IDLE;
        endcase

        // software stop parks the port
        if (!r.run && r.st != ppc_pkg::PPC_IDLE &&
            r.st != ppc_pkg::PPC_CONFIG) begin
            next_r.st     = ppc_pkg::PPC_ERROR;
            next_r.coarse = 8'h00;
            next_r.fine   = 8'h00;
            next_r.cls_en = 1'b0;
            next_r.boost  = 1'b0;
            next_r.cnt    = 32'h0;
        end

        // led pattern per state
        next_r.flash = r.flash + 32'h1;
        unique case (r.st)
            ppc_pkg::PPC_DETECT: begin
                if (r.flash >= 32'(SLOW_HALF_CYC - 1)) begin
                    next_r.flash = 32'h0;
                    next_r.led   = !r.led;
                end
            end
            ppc_pkg::PPC_ERROR: begin
                if (r.flash >= 32'(FAST_HALF_CYC - 1)) begin
                    next_r.flash = 32'h0;
                    next_r.led   = !r.led;
                end
            end
            ppc_pkg::PPC_POWER: begin
                next_r.flash = 32'h0;
                next_r.led   = 1'b1;
            end
            default: begin
                next_r.flash = 32'h0;
                next_r.led   = 1'b0;
            end
        endcase

        // open drain: pull low whenever classification is off
        next_r.cls_oe = !next_r.cls_en;

        // synchronised reset forces the inactive state
        if (!rst_sync) begin
            next_r.st     = ppc_pkg::PPC_IDLE;
            next_r.coarse = 8'h00;
            next_r.fine   = 8'h00;
            next_r.boost  = 1'b0;
            next_r.cls_en = 1'b0;
            next_r.cls_oe = 1'b1;
            next_r.led    = 1'b0;
        end
    end

    // state register
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            r        <= '0;
            r.st     <= ppc_pkg::PPC_IDLE;
            r.run    <= ppc_pkg::CTRL_RUN_RST;
            r.duty   <= ppc_pkg::DUTY_RST;
            r.gate   <= ppc_pkg::GATE_RST;
            r.cls_oe <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // outputs from flip-flops, class_voltage_enable_out tied low
    assign coarse_pwm_out              = r.pwm_c;
    assign fine_pwm_out                = r.pwm_f;
    assign mark_current_boost_out      = r.boost;
    assign class_voltage_enable_out    = 1'b0;
    assign class_voltage_enable_oe_out = r.cls_oe;
    assign status_pin_out              = r.led;
    assign status_pin_oe_out           = r.led_oe;
    assign prdata_out                  = r.prdata;
    assign pready_out                  = r.pready;
    assign pslverr_out                 = r.pslverr;

endmodule : ppc_top

// ==== tb_pse_port_pin_control.sv ====
// self-checking bench for the port pin controller
`timescale 1ns/1ps
module tb_pse_port_pin_control;
    localparam int SLOW = 40;
    localparam int FAST = 10;
    logic        mclk = 1'b0, rst_n = 1'b0, sel = 1'b0, en = 1'b0;
    logic        wr = 1'b0, sense = 1'b0, fault = 1'b0, open_c = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic [2:0]  ccode = 3'h0;
    logic [3:0]  lvl = 4'h3;
    logic [31:0] rd, rv;
    logic        rdy, err, ev, coarse, fine, boost, cls_out, cls_oe;
    logic        cls_pin, st_out, st_oe, st_pin;
    logic        seen_boost = 1'b0, seen_cls = 1'b0;
    int          errors = 0, compares = 0, cycles = 0, n;
    always #25 mclk = ~mclk;
    ppc_top #(.SLOW_HALF_CYC(SLOW), .FAST_HALF_CYC(FAST),
        .RESTART_CYC(200), .DET_STEP_CYC(300), .CLASS_PHASE_CYC(100)) uut (
        .mclk_in(mclk), .rst_n_in(rst_n), .psel_in(sel), .penable_in(en),
        .pwrite_in(wr), .paddr_in(addr), .pwdata_in(wd), .prdata_out(rd),
        .pready_out(rdy), .pslverr_out(err), .detect_sense_in(sense),
        .class_code_in(ccode), .fault_in(fault), .open_circuit_in(open_c),
        .coarse_pwm_out(coarse), .fine_pwm_out(fine),
        .mark_current_boost_out(boost), .class_voltage_enable_in(cls_pin),
        .class_voltage_enable_out(cls_out),
        .class_voltage_enable_oe_out(cls_oe), .status_level_in(lvl),
        .status_pin_in(st_pin), .status_pin_out(st_out),
        .status_pin_oe_out(st_oe));
    ppc_far_side far (.mclk_in(mclk), .class_oe_in(cls_oe),
        .status_oe_in(st_oe), .status_drv_in(st_out),
        .class_pin_out(cls_pin), .status_pin_out(st_pin));
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask : cyc
    // one apb transfer, held until ready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        sel <= 1'b1;
        en <= 1'b0;
        wr <= w;
        addr <= a;
        wd <= d;
        @(posedge mclk);
        en <= 1'b1;
        do @(posedge mclk); while (rdy !== 1'b1);
        rv = rd;
        ev = err;
        sel <= 1'b0;
        en <= 1'b0;
    endtask : apb
    task automatic wait_state(input logic [2:0] s, input int lim);
        for (int i = 0; i < lim; i++) begin
            apb(1'b0, ppc_pkg::STAT_OFS, 32'h0);
            if (rv[2:0] === s) break;
        end
        chk("state", {29'h0, s}, {29'h0, rv[2:0]});
    endtask : wait_state
    task automatic hi_count(input logic f);
        n = 0;
        cyc(4);
        repeat (256) begin
            @(posedge mclk);
            n += int'(f ? fine : coarse);
        end
    endtask : hi_count
    // cycles between two led edges
    task automatic led_run();
        logic v;
        v = st_out;
        for (int i = 0; i < 200 && st_out === v; i++) @(posedge mclk);
        v = st_out;
        n = 0;
        while (st_out === v && n < 200) begin
            @(posedge mclk);
            n++;
        end
    endtask : led_run
    task automatic t_regs();
        apb(1'b0, ppc_pkg::CTRL_OFS, 32'h0);
        chk("ctrl reset", 32'h0000_0001, rv);
        apb(1'b0, ppc_pkg::DUTY_OFS, 32'h0);
        chk("duty reset", 32'h00C0_8040, rv);
        apb(1'b0, ppc_pkg::GATE_OFS, 32'h0);
        chk("gate reset", 32'h0000_FF00, rv);
        apb(1'b1, ppc_pkg::DUTY_OFS, 32'h0080_8080);
        apb(1'b0, ppc_pkg::DUTY_OFS, 32'h0);
        chk("duty write", 32'h0080_8080, rv);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, ev});
        apb(1'b1, ppc_pkg::STAT_OFS, 32'hFFFF_FFFF);
        chk("status write error", 32'h0, {31'h0, ev});
    endtask : t_regs
    task automatic t_config();
        cyc(30);
        chk("status oe", 32'h1, {31'h0, st_oe});
        apb(1'b0, ppc_pkg::STAT_OFS, 32'h0);
        chk("config", 32'h3, {28'h0, rv[6:3]});
        lvl <= 4'hC;
        apb(1'b0, ppc_pkg::STAT_OFS, 32'h0);
        chk("config held", 32'h3, {28'h0, rv[6:3]});
    endtask : t_config
    task automatic t_detect();
        wait_state(3'h2, 50);
        hi_count(1'b0);
        chk("detect duty", 32'h80, n);
        led_run();
        chk("slow half period", SLOW, n);
    endtask : t_detect
    task automatic t_power();
        apb(1'b1, ppc_pkg::GATE_OFS, 32'h0000_8020);
        ccode <= 3'h1;
        sense <= 1'b1;
        wait_state(3'h4, 800);
        hi_count(1'b0);
        chk("gate coarse", 32'h80, n);
        hi_count(1'b1);
        chk("gate fine", 32'h20, n);
        chk("led steady", 32'h1, {31'h0, st_out});
        chk("boost seen", 32'h1, {31'h0, seen_boost});
        chk("class enabled", 32'h1, {31'h0, seen_cls});
    endtask : t_power
    task automatic t_error();
        sense <= 1'b0;
        fault <= 1'b1;
        wait_state(3'h5, 20);
        fault <= 1'b0;
        led_run();
        chk("fast half period", FAST, n);
        cyc(120);
        wait_state(3'h5, 1);
        wait_state(3'h2, 60);
    endtask : t_error
    task automatic t_excess();
        rst_n <= 1'b0;
        lvl <= 4'h8;
        cyc(10);
        chk("reset led", 32'h0, {31'h0, st_out});
        chk("reset class oe", 32'h1, {31'h0, cls_oe});
        rst_n <= 1'b1;
        ccode <= 3'h2;
        sense <= 1'b1;
        wait_state(3'h5, 800);
        cyc(300);
        wait_state(3'h5, 1);
        open_c <= 1'b1;
        wait_state(3'h2, 20);
        apb(1'b1, ppc_pkg::CTRL_OFS, 32'h0);
        wait_state(3'h5, 2);
        chk("stop boost", 32'h0, {31'h0, boost});
        apb(1'b1, ppc_pkg::CTRL_OFS, 32'h1);
        wait_state(3'h2, 5);
    endtask : t_excess
    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    // watchdog and pin monitors
    always @(posedge mclk) begin
        cycles++;
        if (boost === 1'b1) seen_boost <= 1'b1;
        if (cls_pin === 1'b1 && rst_n === 1'b1) seen_cls <= 1'b1;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        cyc(10);
        rst_n <= 1'b1;
        t_regs();
        t_config();
        t_detect();
        t_power();
        t_error();
        t_excess();
        print_verdict();
    end
endmodule : tb_pse_port_pin_control
bind ppc_top ppc_props #(.CLASS_PHASE_CYC(CLASS_PHASE_CYC)) u_props (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .paddr_in(paddr_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .coarse_pwm_out(coarse_pwm_out),
    .mark_current_boost_out(mark_current_boost_out),
    .class_voltage_enable_out(class_voltage_enable_out),
    .class_voltage_enable_oe_out(class_voltage_enable_oe_out),
    .status_pin_out(status_pin_out), .status_pin_oe_out(status_pin_oe_out));
